//--- bench/srf_bus_host.sv
// srf_bus_host.sv: behavioural two-wire bus host driving the frame target.
// assumes a pull-up on sda; scl stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module srf_bus_host (
  output logic scl,
  output logic sda_low,
  input wire sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // sda moves mid-low and is sampled mid-high, so the 3-cycle answer settles
  task automatic bit_io(input logic b, output logic r);
    #8 sda_low = !b;
    #8 scl = 1'b1;
    #8 r = sda;
    #8 scl = 1'b0;
  endtask
  task automatic start_cond();
    #1.3 sda_low = 1'b1;
    #8 scl = 1'b0;
  endtask
  task automatic stop_cond();
    #8 sda_low = 1'b1;
    #8 scl = 1'b1;
    #8 sda_low = 1'b0;
    #16;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_bits(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wake(input logic [7:0] a, output logic ack);
    start_cond();
    put_byte(a, ack);
    #400;
    stop_cond();
  endtask
  task automatic send(input logic [7:0] q[$], output logic ack);
    logic k;
    start_cond();
    put_byte(8'hb8, ack);
    foreach (q[i]) put_byte(q[i], k);
    stop_cond();
  endtask
  task automatic collect(input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    logic k;
    q = {};
    start_cond();
    put_byte(8'hb9, k);
    #200;
    for (int i = 0; i < n; i++)
    begin
      get_bits(i == n - 1, b);
      q.push_back(b);
    end
    stop_cond();
  endtask
endmodule // srf_bus_host
`default_nettype wire

//--- bench/srf_frame_target_properties.sv
// srf_frame_target_properties.sv: port-level checks of the frame target.
// assumes a bind to srf_frame_target from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module srf_frame_target_properties (
  input wire ref_clk,
  input wire rst,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire [15:0] hum_tenths,
  input wire [15:0] temp_tenths,
  input wire awake,
  input wire crc_err,
  input wire [31:0] user_regs
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_rst_out;
    $fell(rst) |-> !sda_oe && !awake && !crc_err && user_regs == 32'h0;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not quiet after reset");
  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda value not low");
  property p_crc_pulse;
    crc_err |=> !crc_err;
  endproperty
  a_crc_pulse: assert property (p_crc_pulse)
    else $error("crc error longer than one cycle");
  property p_crc_idle;
    crc_err |-> awake && scl_i && sda_i;
  endproperty
  a_crc_idle: assert property (p_crc_idle)
    else $error("crc error outside frame end");
  property p_crc_keep;
    crc_err |-> $stable(user_regs) [*3];
  endproperty
  a_crc_keep: assert property (p_crc_keep)
    else $error("registers changed on bad crc");
  // the target may only move sda while scl is low, else it makes a start or stop
  property p_oe_low_scl;
    $changed(sda_oe) |-> !$past(scl_i) && !$past(scl_i, 2);
  endproperty
  a_oe_low_scl: assert property (p_oe_low_scl)
    else $error("sda drive changed while scl high");
  property p_oe_hold;
    $rose(scl_i) |=> $stable(sda_oe) [*4];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("sda drive not held over scl high");
  property p_oe_awake;
    sda_oe |-> awake;
  endproperty
  a_oe_awake: assert property (p_oe_awake)
    else $error("sda driven while asleep");
  property p_regs_idle;
    $changed(user_regs) |-> awake && scl_i && sda_i;
  endproperty
  a_regs_idle: assert property (p_regs_idle)
    else $error("user registers changed outside frame end");
  property p_sleep_stop;
    $fell(awake) |-> scl_i && sda_i;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("sleep entered before stop");
endmodule // srf_frame_target_properties
`default_nettype wire

//--- bench/srf_frame_target_test.sv
// srf_frame_target_test.sv: self-checking bench of the frame target.
// assumes the host model drives the bus; hum/temp are driven at falling edges.
`timescale 1ns/1ps
`default_nettype none
module srf_frame_target_test;
  logic ref_clk;
  logic rst;
  logic [15:0] hum;
  logic [15:0] temp;
  logic [15:0] lfsr_q;
  logic [7:0] ureg [4];
  logic a;
  int mismatches;
  int n_checks;
  int n_crc;
  int exp_crc;
  wire scl;
  wire host_low;
  wire sda_o;
  wire sda_oe;
  wire awake;
  wire crc_err;
  wire [31:0] user_regs;
  // pull-up: low when either party pulls
  wire sda_w = !(host_low || sda_oe);
  srf_frame_target dut_u (.ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .hum_tenths(hum), .temp_tenths(temp),
    .awake(awake), .crc_err(crc_err), .user_regs(user_regs));
  srf_bus_host host_u (.scl(scl), .sda_low(host_low), .sda(sda_w));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = !ref_clk;
  end
  always @(posedge ref_clk)
    if (crc_err === 1'b1) n_crc <= n_crc + 1;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic void seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction
  function automatic logic [7:0] reg_val(input int r);
    logic [15:0] m;
    m = temp[15] ? -temp : temp;
    case (r)
      0: return hum[15:8];
      1: return hum[7:0];
      2: return {temp[15], m[14:8]};
      3: return m[7:0];
      16, 17, 18, 19: return ureg[r - 16];
      default: return 8'h00;
    endcase
  endfunction
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_frame(input logic [7:0] e[$], input logic [7:0] g[$]);
    cmp(e.size(), g.size());
    foreach (e[i]) cmp(e[i], g[i]);
  endtask
  task automatic txn(input logic [7:0] c[$], input int n, output logic [7:0] g[$]);
    logic k;
    host_u.wake(8'hb8, k);
    cmp(1'b0, k);
    cmp(1'b1, awake);
    host_u.send(c, k);
    cmp(1'b1, k);
    repeat (40) @(negedge ref_clk);
    host_u.collect(n, g);
    repeat (8) @(negedge ref_clk);
    cmp(1'b0, awake);
  endtask
  task automatic do_read(input int st, input int n);
    logic [7:0] c[$];
    logic [7:0] e[$];
    logic [7:0] g[$];
    c = {8'h03, 8'(st), 8'(n)};
    if (n > 10 || n == 0)
      e = {8'h83, 8'h03};
    else
    begin
      e = {8'h03, 8'(n)};
      for (int i = 0; i < n; i++) e.push_back(reg_val(st + i));
    end
    seal(e);
    txn(c, e.size(), g);
    chk_frame(e, g);
    $display("read at %0h count %0d done", st, n);
  endtask
  task automatic do_write(input int st, input int n, input logic bad);
    logic [7:0] c[$];
    logic [7:0] e[$];
    logic [7:0] g[$];
    c = {8'h10, 8'(st), 8'(n)};
    for (int i = 0; i < n; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      c.push_back(lfsr_q[7:0]);
    end
    seal(c);
    if (bad)
      c[c.size() - 1] = c[c.size() - 1] ^ 8'h5a;
    if (bad)
      e = {8'h90, 8'h04};
    else if (n > 10)
      e = {8'h90, 8'h03};
    else if (st < 15 || st + n > 20)
      e = {8'h90, 8'h02};
    else
    begin
      e = {8'h10, 8'(st), 8'(n)};
      for (int i = 0; i < n; i++) ureg[st - 16 + i] = c[3 + i];
    end
    seal(e);
    exp_crc = exp_crc + int'(bad);
    txn(c, e.size(), g);
    chk_frame(e, g);
    cmp(exp_crc, n_crc);
    cmp({ureg[3], ureg[2], ureg[1], ureg[0]}, user_regs);
    $display("write at %0h count %0d bad %0d done", st, n, bad);
  endtask
  task automatic do_func(input logic [7:0] fc);
    logic [7:0] c[$];
    logic [7:0] e[$];
    logic [7:0] g[$];
    c = {fc, 8'h00, 8'h01};
    e = {fc | 8'h80, 8'h01};
    seal(e);
    txn(c, e.size(), g);
    chk_frame(e, g);
    $display("function %0h refused done", fc);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    hum = 16'h0000;
    temp = 16'h0000;
    lfsr_q = 16'h0047;
    exp_crc = 0;
    for (int i = 0; i < 4; i++) ureg[i] = 8'h00;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    host_u.wake(8'ha0, a);
    cmp(1'b0, a);
    cmp(1'b0, awake);
    $display("foreign address done");
    for (int i = 0; i < 2; i++)
    begin
      @(negedge ref_clk);
      lfsr_q = lfsr_next(lfsr_q);
      hum = lfsr_q % 16'd1000;
      temp = (i == 1) ? -(lfsr_q % 16'd400) : (lfsr_q % 16'd400);
      do_read(0, 4);
    end
    do_write(16, 2, 1'b0);
    do_write(18, 2, 1'b0);
    do_write(16, 4, 1'b1);
    do_write(16, 11, 1'b0);
    do_write(4, 2, 1'b0);
    do_func(8'h04);
    do_read(10, 10);
    do_read(0, 11);
    test_done();
  end
endmodule // srf_frame_target_test
bind srf_frame_target srf_frame_target_properties chk_u (.ref_clk(ref_clk), .rst(rst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .hum_tenths(hum_tenths),
  .temp_tenths(temp_tenths), .awake(awake), .crc_err(crc_err), .user_regs(user_regs));
`default_nettype wire

//--- core/srf_fifo.v
// srf_fifo.v: small synchronous fifo, flip-flop storage, valid/ready both sides.
// assumes one clock; clr drops all content in one cycle and wins over a write.
`timescale 1ns/1ps
`default_nettype none

module srf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire clr,
  input wire wr_valid,
  output wire wr_ready,
  input wire [WIDTH-1:0] wr_data,
  output wire rd_valid,
  input wire rd_ready,
  output wire [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire do_wr;
  wire do_rd;
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

  assign wr_ready = (count_q != FULL_COUNT);
  assign rd_valid = (count_q != {(AW+1){1'b0}});
  assign rd_data = mem_q[rd_ptr_q];
  assign do_wr = wr_valid & wr_ready;
  assign do_rd = rd_valid & rd_ready;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (do_wr)
      mem_q[wr_ptr_q] <= wr_data;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else if (clr)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (do_rd)
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (do_wr & ~do_rd)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (do_rd & ~do_wr)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // srf_fifo

`default_nettype wire

//--- core/srf_frame_target.v
// srf_frame_target.v: two-wire bus target that runs the register frame protocol
// of a temperature and humidity sensor, with crc-16 on write frames and all responses.
// assumes scl/sda come from the host asynchronously; sda is open drain, driven
// low only while sda_oe is high. measurement values arrive on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "srf_map.vh"

// Functional notes
// - temperature byte pair: bit 15 sign, one negative, bits 14..0 magnitude
// - temperature magnitude counts tenths of a degree celsius
// - status register bits all reserved, no function, read as zero
// - read request: address with write bit, 0x03, start, count, stop
// - response collected in a separate read transaction, then stop
// - read response: 0x03, byte count, data ascending, then crc
// - four registers from zero give humidity high, low, temperature high, low
// - each register is one byte; counts are numbers of registers
// - more than ten registers per frame answered by an error code
// - after a write, confirmation of 0x10, start, count and crc is readable
// - write requests and all responses end with a 16-bit crc
// - crc travels low byte first, then high byte
// - crc covers function code onward, never the bus address byte
// - receiver recomputes crc, compares, flags an error on mismatch
// - crc preset to all ones, each byte xored into the low eight bits
// - eight right shifts per byte, polynomial xor when a one falls out
// - final code is the swapped accumulator; low accumulator byte goes first
// - answers only bus address 0xb8, so one such device per bus
// - wake: start and address, no acknowledge, wait, then stop
module srf_frame_target (
  input wire ref_clk,
  input wire rst,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  input wire [15:0] hum_tenths,
  input wire [15:0] temp_tenths,
  output wire awake,
  output wire crc_err,
  output wire [31:0] user_regs
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_RX = 3'h2;
  localparam [2:0] ST_AACK = 3'h3;
  localparam [2:0] ST_AHOLD = 3'h4;
  localparam [2:0] ST_TX = 3'h5;
  localparam [2:0] ST_TACK = 3'h6;

  // crc of one byte, bit by bit as the reflected algorithm runs
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] b;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (i = 0; i < 8; i = i + 1)
      begin
        if (t[0])
          t = {1'b0, t[15:1]} ^ `SRF_CRC_POLY;
        else
          t = {1'b0, t[15:1]};
      end
      crc_byte = t;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detection
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg scl_prev_q;
  reg sda_prev_q;
  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg rw_q;
  reg in_xfer_q;
  reg oe_q;
  reg sda_o_q;
  reg awake_q;
  reg frame_end_q;
  reg [4:0] rx_idx_q;
  reg [15:0] crc_rx_q;
  reg [7:0] rxbuf_q [0:`SRF_RXBUF_DEPTH-1];
  wire [7:0] byte_in = {sh_q[6:0], sda_s};
  wire fifo_rd_valid;
  wire [7:0] fifo_rd_data;
  wire [7:0] tx_byte = fifo_rd_valid ? fifo_rd_data : 8'hff;
  wire fifo_pop = (st_q == ST_AHOLD) & scl_fall & rw_q & ~start_ev & ~stop_ev;
  wire addr_hit = (byte_in[7:1] == `SRF_ADDR7);

  always @(posedge ref_clk)
  begin
    if ((st_q == ST_RX) && scl_rise && (bit_q == 4'h7) && !rx_idx_q[4])
      rxbuf_q[rx_idx_q[3:0]] <= byte_in;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      in_xfer_q <= 1'b0;
      oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      awake_q <= 1'b0;
      frame_end_q <= 1'b0;
      rx_idx_q <= 5'h00;
      crc_rx_q <= `SRF_CRC_INIT;
    end
    else
    begin
      frame_end_q <= 1'b0;
      if (start_ev)
      begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        oe_q <= 1'b0;
      end
      else if (stop_ev)
      begin
        st_q <= ST_IDLE;
        oe_q <= 1'b0;
        in_xfer_q <= 1'b0;
        if (in_xfer_q & ~rw_q)
          frame_end_q <= 1'b1;
        // response collected: back to sleep until the next wake
        if (in_xfer_q & rw_q)
          awake_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_ADDR:
            if (scl_rise)
            begin
              sh_q <= byte_in;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7)
              begin
                if (addr_hit & awake_q)
                begin
                  rw_q <= byte_in[0];
                  in_xfer_q <= 1'b1;
                  st_q <= ST_AACK;
                  if (!byte_in[0])
                  begin
                    rx_idx_q <= 5'h00;
                    crc_rx_q <= `SRF_CRC_INIT;
                  end
                end
                else
                begin
                  // sleeping target only wakes, the ninth clock sees no ack
                  if (addr_hit)
                    awake_q <= 1'b1;
                  st_q <= ST_IDLE;
                end
              end
            end
          ST_RX:
            if (scl_rise)
            begin
              sh_q <= byte_in;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7)
              begin
                if (rx_idx_q != `SRF_RX_IDX_MAX)
                  rx_idx_q <= rx_idx_q + 5'h01;
                crc_rx_q <= crc_byte(crc_rx_q, byte_in);
                st_q <= ST_AACK;
              end
            end
          ST_AACK:
            if (scl_fall)
            begin
              oe_q <= 1'b1;
              st_q <= ST_AHOLD;
            end
          ST_AHOLD:
            if (scl_fall)
            begin
              bit_q <= 4'h0;
              if (rw_q)
              begin
                sh_q <= tx_byte;
                oe_q <= ~tx_byte[7];
                st_q <= ST_TX;
              end
              else
              begin
                oe_q <= 1'b0;
                st_q <= ST_RX;
              end
            end
          ST_TX:
            if (scl_fall)
            begin
              if (bit_q == 4'h7)
              begin
                oe_q <= 1'b0;
                st_q <= ST_TACK;
              end
              else
              begin
                oe_q <= ~sh_q[6];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          ST_TACK:
            if (scl_rise)
              st_q <= sda_s ? ST_IDLE : ST_AHOLD;
          default:
            st_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode at the end of a write transaction
  wire [7:0] cmd_fc = rxbuf_q[0];
  wire [7:0] cmd_start = rxbuf_q[1];
  wire [7:0] cmd_cnt = rxbuf_q[2];
  wire cmd_present = (rx_idx_q >= 5'h03);
  wire is_read = (cmd_fc == `SRF_FC_READ);
  wire is_write = (cmd_fc == `SRF_FC_WRITE);
  wire cnt_ok = (cmd_cnt != 8'h00) && (cmd_cnt <= `SRF_MAX_REGS);
  wire [8:0] wr_last = {1'b0, cmd_start} + {1'b0, cmd_cnt} - 9'h001;
  wire range_ok = (cmd_start >= `SRF_REG_STATUS) && (wr_last <= {1'b0, `SRF_REG_WR_LAST});
  wire len_ok = ({4'h0, rx_idx_q} == ({1'b0, cmd_cnt} + 9'h005));
  wire crc_ok = (crc_rx_q == `SRF_CRC_RESIDUE);
  wire wr_commit = frame_end_q & cmd_present & is_write & cnt_ok & len_ok & crc_ok & range_ok;

  ////////////////////////////////////////////////////////////////////////////
  // writable user registers; status at 0x0f accepts writes and keeps nothing
  wire [31:0] user_flat;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_user
      localparam integer GI = g;
      wire [7:0] off = `SRF_REG_USER0 + GI[7:0] - cmd_start;
      wire [3:0] idx = off[3:0] + 4'h3;
      reg [7:0] val_q;
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          val_q <= `SRF_USER_RESET;
        else if (wr_commit && (off < cmd_cnt))
          val_q <= rxbuf_q[idx];
      end
      assign user_flat[8*g +: 8] = val_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // response generator feeding the fifo
  reg gen_busy_q;
  reg gen_read_q;
  reg [7:0] gen_p0_q;
  reg [7:0] gen_p1_q;
  reg [7:0] gen_p2_q;
  reg [3:0] gen_step_q;
  reg [3:0] gen_len_q;
  reg [15:0] gen_crc_q;
  reg [15:0] hum_q;
  reg [15:0] temp_q;
  reg crc_err_q;
  reg [7:0] reg_byte;
  reg [7:0] gen_byte;
  wire fifo_wr_ready;
  wire [7:0] rd_addr = gen_p2_q + {4'h0, gen_step_q} - 8'h02;
  wire [15:0] temp_mag = temp_tenths[15] ? (16'h0000 - temp_tenths) : temp_tenths;
  wire gen_push = gen_busy_q & fifo_wr_ready;
  wire resp_start = frame_end_q & cmd_present;

  always @*
  begin
    case (rd_addr)
      `SRF_REG_HUM_HI: reg_byte = hum_q[15:8];
      `SRF_REG_HUM_LO: reg_byte = hum_q[7:0];
      `SRF_REG_TEMP_HI: reg_byte = temp_q[15:8];
      `SRF_REG_TEMP_LO: reg_byte = temp_q[7:0];
      `SRF_REG_STATUS: reg_byte = `SRF_STATUS_VALUE;
      8'h10: reg_byte = user_flat[7:0];
      8'h11: reg_byte = user_flat[15:8];
      8'h12: reg_byte = user_flat[23:16];
      8'h13: reg_byte = user_flat[31:24];
      default: reg_byte = 8'h00;
    endcase
  end

  always @*
  begin
    if (gen_step_q == gen_len_q - 4'h2)
      gen_byte = gen_crc_q[7:0];
    else if (gen_step_q == gen_len_q - 4'h1)
      gen_byte = gen_crc_q[15:8];
    else if (gen_step_q == 4'h0)
      gen_byte = gen_p0_q;
    else if (gen_step_q == 4'h1)
      gen_byte = gen_p1_q;
    else if ((gen_step_q == 4'h2) && !gen_read_q)
      gen_byte = gen_p2_q;
    else
      gen_byte = reg_byte;
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      gen_busy_q <= 1'b0;
      gen_read_q <= 1'b0;
      gen_p0_q <= 8'h00;
      gen_p1_q <= 8'h00;
      gen_p2_q <= 8'h00;
      gen_step_q <= 4'h0;
      gen_len_q <= 4'h4;
      gen_crc_q <= `SRF_CRC_INIT;
      hum_q <= 16'h0000;
      temp_q <= 16'h0000;
      crc_err_q <= 1'b0;
    end
    else
    begin
      crc_err_q <= resp_start & is_write & ~crc_ok;
      if (resp_start)
      begin
        gen_busy_q <= 1'b1;
        gen_step_q <= 4'h0;
        gen_crc_q <= `SRF_CRC_INIT;
        hum_q <= hum_tenths;
        // input is two's complement tenths; sent as sign and magnitude
        temp_q <= {temp_tenths[15], temp_mag[14:0]};
        gen_read_q <= 1'b0;
        gen_len_q <= 4'h4;
        gen_p0_q <= cmd_fc | `SRF_ERR_FLAG;
        gen_p2_q <= cmd_start;
        if (!is_read && !is_write)
          gen_p1_q <= `SRF_ERR_FUNC;
        else if (!cnt_ok)
          gen_p1_q <= `SRF_ERR_COUNT;
        else if (is_write && (!len_ok || !crc_ok))
          gen_p1_q <= `SRF_ERR_CRC;
        else if (is_write && !range_ok)
          gen_p1_q <= `SRF_ERR_ADDR;
        else if (is_read)
        begin
          gen_read_q <= 1'b1;
          gen_p0_q <= `SRF_FC_READ;
          gen_p1_q <= cmd_cnt;
          gen_len_q <= cmd_cnt[3:0] + 4'h4;
        end
        else
        begin
          gen_p0_q <= `SRF_FC_WRITE;
          gen_p1_q <= cmd_start;
          gen_p2_q <= cmd_cnt;
          gen_len_q <= 4'h5;
        end
      end
      else if (gen_push)
      begin
        if (gen_step_q < gen_len_q - 4'h2)
          gen_crc_q <= crc_byte(gen_crc_q, gen_byte);
        gen_step_q <= gen_step_q + 4'h1;
        if (gen_step_q == gen_len_q - 4'h1)
          gen_busy_q <= 1'b0;
      end
    end
  end

  // a new command drops any unread response so stale bytes never go out
  srf_fifo #(
    .WIDTH(`SRF_FIFO_WIDTH),
    .DEPTH(`SRF_FIFO_DEPTH),
    .AW(`SRF_FIFO_AW)
  ) u_resp_fifo (
    .clk(ref_clk),
    .rst(rst),
    .clr(resp_start),
    .wr_valid(gen_busy_q),
    .wr_ready(fifo_wr_ready),
    .wr_data(gen_byte),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_pop),
    .rd_data(fifo_rd_data)
  );

  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign awake = awake_q;
  assign crc_err = crc_err_q;
  assign user_regs = user_flat;

endmodule // srf_frame_target

`default_nettype wire

//--- pkg/srf_map.vh
// srf_map.vh: constants of the sensor register frame target.
// assumes it is included by bare name from the design files under core/.
`ifndef SRF_MAP_VH
`define SRF_MAP_VH

// bus target address, seven bit form of the 8-bit write byte 0xb8
`define SRF_ADDR7 7'h5c

// function codes and response markers
`define SRF_FC_READ 8'h03
`define SRF_FC_WRITE 8'h10
`define SRF_ERR_FLAG 8'h80

// error codes, values arbitrary
`define SRF_ERR_FUNC 8'h01
`define SRF_ERR_ADDR 8'h02
`define SRF_ERR_COUNT 8'h03
`define SRF_ERR_CRC 8'h04

// register map, one byte per register
`define SRF_REG_HUM_HI 8'h00
`define SRF_REG_HUM_LO 8'h01
`define SRF_REG_TEMP_HI 8'h02
`define SRF_REG_TEMP_LO 8'h03
`define SRF_REG_STATUS 8'h0f
`define SRF_REG_USER0 8'h10
`define SRF_REG_WR_LAST 8'h13
`define SRF_STATUS_VALUE 8'h00
`define SRF_USER_RESET 8'h00

// frame limits
`define SRF_MAX_REGS 8'h0a
`define SRF_RXBUF_DEPTH 16
`define SRF_RX_IDX_MAX 5'h1f

// crc-16: preset, reflected polynomial, residue of a good frame
`define SRF_CRC_INIT 16'hffff
`define SRF_CRC_POLY 16'ha001
`define SRF_CRC_RESIDUE 16'h0000

// response buffer
`define SRF_FIFO_WIDTH 8
`define SRF_FIFO_DEPTH 16
`define SRF_FIFO_AW 4

`endif
